/* File: testbench/tb_top.sv */
// Self-checking bench for the single-pulse PWM timer over AXI4-Lite
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tpw_pkg::*;
  logic        aclk, aresetn, clk_en, external_trigger_pin, cutoff_pin;
  logic        pwm_output_pin, adc_trigger, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          fail_count, checks;
  logic [1:0]  rs;
  logic [31:0] rd;
  int          hi, rises, adcs, settle;

  tpw_single_pulse_pwm_mode #(.CNT_W(16)) tpw_single_pulse_pwm_mode_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .external_trigger_pin(external_trigger_pin), .cutoff_pin(cutoff_pin),
    .pwm_output_pin(pwm_output_pin), .adc_trigger(adc_trigger), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk

  // Channels released one by one as each ready is seen at an edge
  // No wait limit here; the watchdog ends a hung transfer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1 && !awvalid && !wvalid));
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1 && !arvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rs);
    chk("bresp", RESP_OKAY, rs);
  endtask : wr

  // Forty samples at falling edges, where the pin has settled; whole periods fit
  task automatic meas();
    logic prev;
    hi = 0; rises = 0; adcs = 0;
    repeat (settle) @(posedge aclk);
    @(negedge aclk);
    prev = pwm_output_pin;
    repeat (40) begin
      @(negedge aclk);
      if (pwm_output_pin === 1'b1) hi++;
      if (pwm_output_pin === 1'b1 && prev === 1'b0) rises++;
      if (adc_trigger === 1'b1) adcs++;
      prev = pwm_output_pin;
    end
    @(posedge aclk);
  endtask : meas

  task automatic t_regs();
    axr(OFF_CTRL, rd, rs);   chk("ctrl_rst", 32'h0000_0002, rd);
    axr(OFF_PERIOD, rd, rs); chk("period_rst", 32'h0000_ffff, rd);
    axr(OFF_MASK, rd, rs);   chk("mask_rst", 32'h0, rd);
    axr(8'h1c, rd, rs);      chk("rresp_unmapped", RESP_SLV, rs);
    axw(8'h02, 32'h1, rs);   chk("bresp_unaligned", RESP_SLV, rs);
    wr(OFF_COUNT, 32'h55);
    axr(OFF_COUNT, rd, rs);  chk("count_ro", 32'h0, rd);
    wr(OFF_LEAD, 32'h1234_5678);
    axr(OFF_LEAD, rd, rs);   chk("lead_rb", 32'h0000_5678, rd);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pwm();
    wr(OFF_PERIOD, 32'd9);
    wr(OFF_LEAD, 32'd2);
    wr(OFF_TRAIL, 32'd5);
    wr(OFF_CTRL, 32'h43);
    meas();
    chk("active_cycles", 32'd12, hi);
    chk("periods", 32'd4, rises);
    chk("adc_pulses", 32'd4, adcs);
    wr(OFF_CTRL, 32'h103);
    meas();
    chk("div2_active", 32'd12, hi);
    chk("div2_periods", 32'd2, rises);
    chk("adc_off", 32'd0, adcs);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_pol();
    wr(OFF_CTRL, 32'h01);
    meas();
    chk("low_active", 32'd28, hi);
    wr(OFF_CTRL, 32'h04);
    meas();
    chk("init_high", 32'd40, hi);
    wr(OFF_CTRL, 32'h00);
    meas();
    chk("init_low", 32'd0, hi);
    $display("test polarity done");
  endtask : t_pol

  task automatic t_cut();
    cutoff_pin <= 1'b1;
    wr(OFF_CTRL, 32'h23);
    meas();
    chk("cut_on", 32'd0, hi);
    wr(OFF_CTRL, 32'h03);
    meas();
    chk("cut_off", 32'd12, hi);
    cutoff_pin <= 1'b0;
    $display("test cutoff done");
  endtask : t_cut

  task automatic t_irq();
    wr(OFF_CTRL, 32'h00);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_CTRL, 32'h03);
    repeat (20) @(posedge aclk);
    chk("irq_masked", 32'h0, irq);
    axr(OFF_STATUS, rd, rs); chk("status_period", 32'h1, rd & 32'h1);
    wr(OFF_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq_on", 32'h1, irq);
    wr(OFF_CTRL, 32'h00);
    wr(OFF_STATUS, 32'h7);
    repeat (3) @(posedge aclk);
    chk("irq_cleared", 32'h0, irq);
    axr(OFF_STATUS, rd, rs); chk("status_clr", 32'h0, rd);
    $display("test interrupt done");
  endtask : t_irq

  // Restart only counts when the trigger input is enabled
  task automatic t_trg();
    wr(OFF_PERIOD, 32'd1000);
    wr(OFF_CTRL, 32'h13);
    repeat (200) @(posedge aclk);
    external_trigger_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    axr(OFF_COUNT, rd, rs); chk("trg_restart", 32'h1, rd < 30);
    external_trigger_pin <= 1'b0;
    wr(OFF_CTRL, 32'h03);
    repeat (200) @(posedge aclk);
    external_trigger_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    axr(OFF_COUNT, rd, rs); chk("trg_ignored", 32'h1, rd >= 200);
    external_trigger_pin <= 1'b0;
    // Clock enable low must hold the counter
    hi = rd;
    clk_en <= 1'b0;
    repeat (100) @(posedge aclk);
    clk_en <= 1'b1;
    axr(OFF_COUNT, rd, rs); chk("count_frozen", 32'h1, rd - hi < 20);
    $display("test trigger done");
  endtask : t_trg

  // Buffered compares stay unused until the next period match
  task automatic t_buf();
    wr(OFF_CTRL, 32'h00);
    wr(OFF_PERIOD, 32'd9);
    wr(OFF_CTRL, 32'h08);
    wr(OFF_LEAD, 32'h20);
    wr(OFF_TRAIL, 32'h30);
    wr(OFF_CTRL, 32'h0b);
    settle = 0;
    meas();
    settle = 24;
    chk("buf_first_period", 32'd3, hi);
    meas();
    chk("buf_loaded", 32'd0, hi);
    $display("test buffer done");
  endtask : t_buf

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    fail_count = 0; checks = 0; settle = 24;
    aresetn = 1'b0; clk_en = 1'b1; external_trigger_pin = 1'b0; cutoff_pin = 1'b0;
    awaddr = '0; wdata = '0; wstrb = '0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pwm();
    t_pol();
    t_cut();
    t_irq();
    t_trg();
    t_buf();
    print_verdict();
  end

  // Tests need about 1300 cycles; a hang is cut well beyond that
  initial begin
    #(25 * 20000);
    fail_count++;
    print_verdict();
  end
endmodule : tb_top

/* File: verilog/tpw_pkg.sv */
// Constants shared by the single-pulse PWM timer block
package tpw_pkg;
  localparam int          AXI_AW     = 8;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_PERIOD = 8'h04;
  localparam logic [7:0]  OFF_LEAD   = 8'h08;
  localparam logic [7:0]  OFF_TRAIL  = 8'h0c;
  localparam logic [7:0]  OFF_COUNT  = 8'h10;
  localparam logic [7:0]  OFF_STATUS = 8'h14;
  localparam logic [7:0]  OFF_MASK   = 8'h18;
  // Control register fields
  localparam int          CB_RUN     = 0;
  localparam int          CB_POL     = 1;
  localparam int          CB_INIT    = 2;
  localparam int          CB_BUF     = 3;
  localparam int          CB_TRG     = 4;
  localparam int          CB_CUT     = 5;
  localparam int          CB_ADC     = 6;
  localparam int          CB_SRC     = 8;
  localparam int          CTRL_W     = 10;
  // Status and mask fields
  localparam int          ST_PERIOD  = 0;
  localparam int          ST_LEAD    = 1;
  localparam int          ST_TRAIL   = 2;
  localparam int          ST_W       = 3;
  // Values after reset: active high, initial level low, stopped
  localparam logic [9:0]  CTRL_RST   = 10'h002;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] LEAD_RST   = 16'h0000;
  localparam logic [15:0] TRAIL_RST  = 16'h0000;
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam int          PRE_W      = 3;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage : tpw_pkg

/* File: verilog/tpw_single_pulse_pwm_mode.sv */
// Single-pulse PWM timer with AXI4-Lite register slave
// Functional notes
// (R1) Counter clears after matching period register
// (R2) Period lasts period value plus one counts
// (R3) Output goes active at leading-edge match
// (R4) Pulse width is trailing minus leading value
// (R5) Software selects active polarity and initial level
// (R6) Period match raises the timer interrupt
// (R7) Undivided clock selectable as count source
// (R8) Buffer operation can be switched off
// (R9) Trigger, cutoff, converter trigger independently disabled
// (R10) Output returns inactive at every period restart unless the leading compare is zero
module tpw_single_pulse_pwm_mode #(
  parameter int CNT_W = 16
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        clk_en,
  input  wire logic                        external_trigger_pin,
  input  wire logic                        cutoff_pin,
  output logic                             pwm_output_pin,
  output logic                             adc_trigger,
  output logic                             irq,
  input  wire logic [tpw_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [tpw_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready
);
  import tpw_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_MASK);
  endfunction : mapped

  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  pwm_counter;
  logic [CNT_W-1:0]  period_compare_reg;
  logic [CNT_W-1:0]  leading_edge_compare;
  logic [CNT_W-1:0]  trailing_edge_compare;
  logic [CNT_W-1:0]  sh_period;
  logic [CNT_W-1:0]  sh_lead;
  logic [CNT_W-1:0]  sh_trail;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic [PRE_W-1:0]  pre;
  logic              pwm_active;
  logic              trg_s1;
  logic              trg_s2;
  logic              trg_d;
  logic              cut_s1;
  logic              cut_s2;
  logic              aw_got;
  logic              w_got;
  logic [AXI_AW-1:0] waddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  // Control fields
  wire       run               = ctrl[CB_RUN];
  wire       pol               = ctrl[CB_POL];
  wire       init_lvl          = ctrl[CB_INIT];
  wire       buffer_mode_select = ctrl[CB_BUF];
  wire       trg_en            = ctrl[CB_TRG];
  wire       cut_en            = ctrl[CB_CUT];
  wire       adc_en            = ctrl[CB_ADC];
  wire [1:0] src               = ctrl[CB_SRC +: 2];

  // Source 0 is the undivided clock; others divide by 2, 4, 8
  wire [PRE_W-1:0] src_mask = PRE_W'((4'h1 << src) - 4'h1);
  wire tick         = clk_en & run & ((pre & src_mask) == src_mask); // R7
  wire trg_rise     = trg_s2 & ~trg_d;
  wire trig_restart = clk_en & run & trg_en & trg_rise; // R9
  wire cut_act      = cut_en & cut_s2; // R9
  wire period_hit   = tick & (pwm_counter == period_compare_reg); // R1 R6
  wire step         = tick | trig_restart;
  wire [CNT_W-1:0] next_count = (trig_restart | period_hit) ? '0 : // R1 R2
                                CNT_W'(pwm_counter + 1'b1);
  // Compare against the next count so the pin changes as the counter lands
  wire restart_hit  = step & (next_count == '0);
  wire lead_hit     = step & (next_count == leading_edge_compare); // R3
  wire trail_hit    = step & (next_count == trailing_edge_compare); // R4

  logic next_active;
  always_comb begin
    next_active = pwm_active;
    if (restart_hit) begin
      next_active = 1'b0; // R10
    end
    if (lead_hit) begin
      next_active = 1'b1; // R3
    end
    if (trail_hit) begin
      next_active = 1'b0; // R4
    end
    if (cut_act || !run) begin
      next_active = 1'b0;
    end
  end
  wire next_pin = !run ? init_lvl : (next_active ? pol : ~pol); // R5

  // Register write path
  wire aw_hs      = awvalid & awready;
  wire w_hs       = wvalid & wready;
  wire write_fire = clk_en & aw_got & w_got & ~bvalid;
  wire wr_ok      = mapped(waddr_q);
  wire [31:0] wr_ctrl   = merge(32'(ctrl), wdata_q, wstrb_q);
  wire [31:0] wr_period = merge(32'(sh_period), wdata_q, wstrb_q);
  wire [31:0] wr_lead   = merge(32'(sh_lead), wdata_q, wstrb_q);
  wire [31:0] wr_trail  = merge(32'(sh_trail), wdata_q, wstrb_q);
  wire [31:0] wr_mask   = merge(32'(mask), wdata_q, wstrb_q);
  wire we_ctrl   = write_fire & (waddr_q == OFF_CTRL);
  wire we_period = write_fire & (waddr_q == OFF_PERIOD);
  wire we_lead   = write_fire & (waddr_q == OFF_LEAD);
  wire we_trail  = write_fire & (waddr_q == OFF_TRAIL);
  wire we_status = write_fire & (waddr_q == OFF_STATUS) & wstrb_q[0];
  wire we_mask   = write_fire & (waddr_q == OFF_MASK);
  // Buffered compares reach the counter only at a period match
  wire load_buf  = buffer_mode_select & period_hit; // R8

  // A new event wins over a simultaneous write-one-to-clear
  wire [ST_W-1:0] events      = {trail_hit, lead_hit, period_hit};
  wire [ST_W-1:0] clr_bits    = we_status ? wdata_q[ST_W-1:0] : '0;
  wire [ST_W-1:0] next_status = (status & ~clr_bits) | events;
  wire [ST_W-1:0] next_mask   = we_mask ? wr_mask[ST_W-1:0] : mask;

  // Register read path
  wire [31:0] rd_word =
    (araddr == OFF_CTRL)   ? 32'(ctrl) :
    (araddr == OFF_PERIOD) ? 32'(sh_period) :
    (araddr == OFF_LEAD)   ? 32'(sh_lead) :
    (araddr == OFF_TRAIL)  ? 32'(sh_trail) :
    (araddr == OFF_COUNT)  ? 32'(pwm_counter) :
    (araddr == OFF_STATUS) ? 32'(status) :
    (araddr == OFF_MASK)   ? 32'(mask) : 32'h0000_0000;

  // Asynchronous pins pass two flip-flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_d  <= 1'b0;
      cut_s1 <= 1'b0;
      cut_s2 <= 1'b0;
    end else if (clk_en) begin
      trg_s1 <= external_trigger_pin;
      trg_s2 <= trg_s1;
      trg_d  <= trg_s2;
      cut_s1 <= cutoff_pin;
      cut_s2 <= cut_s1;
    end
  end

  // Counter, prescaler and output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre            <= '0;
      pwm_counter    <= '0;
      pwm_active     <= 1'b0;
      pwm_output_pin <= 1'b0;
      adc_trigger    <= 1'b0;
    end else if (clk_en) begin
      pre            <= run ? PRE_W'(pre + 1'b1) : '0;
      pwm_active     <= next_active;
      pwm_output_pin <= next_pin;
      adc_trigger    <= adc_en & period_hit; // R9
      if (!run) begin
        pwm_counter <= '0;
      end else if (step) begin
        pwm_counter <= next_count; // R1
      end
    end
  end

  // Configuration and compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                  <= CTRL_RST;
      sh_period             <= CNT_W'(PERIOD_RST);
      sh_lead               <= CNT_W'(LEAD_RST);
      sh_trail              <= CNT_W'(TRAIL_RST);
      period_compare_reg    <= CNT_W'(PERIOD_RST);
      leading_edge_compare  <= CNT_W'(LEAD_RST);
      trailing_edge_compare <= CNT_W'(TRAIL_RST);
      mask                  <= MASK_RST;
      status                <= '0;
      irq                   <= 1'b0;
    end else if (clk_en) begin
      status <= next_status;
      irq    <= |(next_status & next_mask); // R6
      if (we_ctrl) begin
        ctrl <= wr_ctrl[CTRL_W-1:0];
      end
      mask <= next_mask;
      if (we_period) begin
        sh_period <= wr_period[CNT_W-1:0];
      end
      if (we_lead) begin
        sh_lead <= wr_lead[CNT_W-1:0];
      end
      if (we_trail) begin
        sh_trail <= wr_trail[CNT_W-1:0];
      end
      if (load_buf) begin
        period_compare_reg    <= sh_period;
        leading_edge_compare  <= sh_lead;
        trailing_edge_compare <= sh_trail;
      end else if (!buffer_mode_select) begin
        if (we_period) begin
          period_compare_reg <= wr_period[CNT_W-1:0]; // R8
        end
        if (we_lead) begin
          leading_edge_compare <= wr_lead[CNT_W-1:0]; // R8
        end
        if (we_trail) begin
          trailing_edge_compare <= wr_trail[CNT_W-1:0]; // R8
        end
      end
    end
  end

  // AXI4-Lite handshakes; one write and one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (aw_hs) begin
        aw_got  <= 1'b1;
        awready <= 1'b0;
        waddr_q <= awaddr;
      end
      if (w_hs) begin
        w_got   <= 1'b1;
        wready  <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (write_fire) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLV;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLV;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_r1;
    period_hit && !trig_restart |=> pwm_counter == '0;
  endproperty
  a_r1: assert property (p_r1) else $error("counter did not clear on period"); // R1
  property p_r2;
    tick && !period_hit && !trig_restart |=> pwm_counter == CNT_W'($past(pwm_counter) + 1'b1);
  endproperty
  a_r2: assert property (p_r2) else $error("counter did not advance"); // R2
  property p_r3;
    lead_hit && !trail_hit && !cut_act |=> pwm_active && pwm_output_pin == $past(pol);
  endproperty
  a_r3: assert property (p_r3) else $error("leading edge missed"); // R3
  property p_r4;
    trail_hit |=> !pwm_active ##0 pwm_output_pin == !$past(pol);
  endproperty
  a_r4: assert property (p_r4) else $error("trailing edge missed"); // R4
  property p_r5;
    clk_en && !run |=> pwm_output_pin == $past(init_lvl);
  endproperty
  a_r5: assert property (p_r5) else $error("initial level not driven"); // R5
  property p_r6;
    period_hit |=> status[ST_PERIOD] && (irq || !mask[ST_PERIOD]);
  endproperty
  a_r6: assert property (p_r6) else $error("period event lost"); // R6
  property p_r7;
    clk_en && run && src == 2'h0 && pwm_counter != '0 |=> pwm_counter != $past(pwm_counter);
  endproperty
  a_r7: assert property (p_r7) else $error("undivided source stalled"); // R7
  property p_r8;
    we_lead && !buffer_mode_select && wstrb_q == 4'hf |=>
      leading_edge_compare == $past(wdata_q[CNT_W-1:0]);
  endproperty
  a_r8: assert property (p_r8) else $error("direct compare write lost"); // R8
  property p_r9;
    clk_en && !adc_en |=> !adc_trigger;
  endproperty
  a_r9: assert property (p_r9) else $error("disabled converter trigger acted"); // R9
  property p_r10;
    restart_hit && !lead_hit |=> !pwm_active;
  endproperty
  a_r10: assert property (p_r10) else $error("output not reset at restart"); // R10
endmodule : tpw_single_pulse_pwm_mode
